// ==== logic/sbs_pkg.sv ====
// package for the shared bus steering and power block
package sbs_pkg;
    // register byte addresses on the apb slave
    localparam logic [7:0] ADDR_BUS_MODE   = 8'h04;
    localparam logic [7:0] ADDR_ALT_START  = 8'h08;
    localparam logic [7:0] ADDR_MEM_CFG    = 8'h0c;
    localparam logic [7:0] ADDR_DATA_PWR   = 8'h10;
    localparam logic [7:0] ADDR_STATUS     = 8'h14;
    // printed index of the bus activity mode register
    localparam logic [7:0] IDX_BUS_MODE    = 8'h01;
    // field positions
    localparam int BIT_INHIBIT     = 2;
    localparam int BIT_LATCH       = 3;
    localparam int BIT_ALT_EN      = 7;
    localparam int BIT_WIN_SEL     = 3;
    localparam int BIT_SMALL_BUF   = 4;
    localparam int BIT_ROM1_WIDE   = 5;
    localparam int BIT_CMEM_WIDE   = 6;
    localparam int BIT_CIO_WIDE    = 7;
    localparam int BIT_HOLD_EN     = 0;
    localparam int BIT_CLAMP_EN    = 1;
    localparam int BIT_ROM_OE_EN   = 2;
    // reset values
    localparam logic [7:0] RST_BUS_MODE  = 8'h00;
    localparam logic [7:0] RST_ALT_START = 8'h00;
    localparam logic [7:0] RST_MEM_CFG   = 8'h07;
    localparam logic [7:0] RST_TOM       = 8'h28;
    localparam logic [7:0] RST_DATA_PWR  = 8'h00;
    // 16 kbyte page numbers of the display windows and the dos top in cpu space
    localparam logic [5:0] PG_WIN_B8     = 6'h2e;
    localparam logic [5:0] PG_WIN_A0     = 6'h28;
    localparam logic [5:0] PG_DOS_TOP    = 6'h28;
    // one-hot states of the bus cycle sequencer
    typedef enum logic [3:0]
    {
        ST_IDLE  = 4'b0001,
        ST_ADDR  = 4'b0010,
        ST_DATA  = 4'b0100,
        ST_DONE  = 4'b1000
    } sbs_state_t;
    // target codes of a bus cycle
    typedef enum logic [2:0]
    {
        TGT_RAM   = 3'h0,
        TGT_ROM0  = 3'h1,
        TGT_ROM1  = 3'h2,
        TGT_XMEM  = 3'h3,
        TGT_XIO   = 3'h4,
        TGT_CMEM  = 3'h5,
        TGT_CIO   = 3'h6,
        TGT_INT   = 3'h7
    } sbs_tgt_t;
endpackage : sbs_pkg

// ==== logic/sbs_steer.sv ====
// byte steering and target width selection
`timescale 1ns/1ps
module sbs_steer
(
    // cycle description
    input  wire logic [2:0]  tgt,
    input  wire logic        odd_byte,
    input  wire logic        word_op,
    input  wire logic        second_half,
    input  wire logic [15:0] wdata,
    // width sources
    input  wire logic        rom0_width_pin,
    input  wire logic        rom1_width_bit,
    input  wire logic        card_mem_size_bit,
    input  wire logic        card_io_size_bit,
    input  wire logic        card_wp_pin,
    input  wire logic        memcs16_en,
    input  wire logic        memcs16_n,
    input  wire logic        iocs16_en,
    input  wire logic        iocs16_n,
    // results
    output logic             wide,
    output logic             split,
    output logic [1:0]       lanes,
    output logic [15:0]      pin_data
);
    always_comb
    begin
        case (sbs_pkg::sbs_tgt_t'(tgt))
            sbs_pkg::TGT_RAM:  wide = 1'b1;
            sbs_pkg::TGT_ROM0: wide = rom0_width_pin;
            sbs_pkg::TGT_ROM1: wide = rom1_width_bit;
            sbs_pkg::TGT_XMEM: wide = memcs16_en & ~memcs16_n;
            sbs_pkg::TGT_XIO:  wide = iocs16_en & ~iocs16_n;
            sbs_pkg::TGT_CMEM: wide = card_mem_size_bit;
            sbs_pkg::TGT_CIO:  wide = card_io_size_bit | card_wp_pin;
            default:           wide = 1'b1;
        endcase
    end
    always_comb
    begin
        split = word_op & ~wide;
        if (word_op && wide)
        begin
            lanes    = 2'b11;
            pin_data = wdata;
        end
        else if (word_op)
        begin
            lanes    = 2'b01;
            pin_data = {8'h00, second_half ? wdata[15:8] : wdata[7:0]};
        end
        else if (odd_byte && wide)
        begin
            lanes    = 2'b10;
            pin_data = {wdata[15:8], 8'h00};
        end
        else if (odd_byte)
        begin
            lanes    = 2'b01;
            pin_data = {8'h00, wdata[15:8]};
        end
        else
        begin
            lanes    = 2'b01;
            pin_data = {8'h00, wdata[7:0]};
        end
    end
endmodule : sbs_steer

// ==== logic/sbs_bridge.sv ====
// shared bus bridge: display mapping, address, data and strobe control
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
module sbs_bridge
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // cpu cycle request
    input  wire logic        cyc_start,
    input  wire logic        cyc_io,
    input  wire logic        cyc_write,
    input  wire logic        cyc_word,
    input  wire logic [2:0]  cyc_tgt,
    input  wire logic [19:0] cpu_address_bits,
    input  wire logic [15:0] cyc_wdata,
    output logic             cyc_done,
    output logic             cyc_block,
    output logic [15:0]      cyc_rdata,
    // lcd refresh master
    input  wire logic        refresh_req,
    input  wire logic [15:1] refresh_word_offset,
    // width sources and power state
    input  wire logic        rom0_width_pin,
    input  wire logic        card_wp_pin,
    input  wire logic        memcs16_en,
    input  wire logic        memcs16_n,
    input  wire logic        iocs16_en,
    input  wire logic        iocs16_n,
    input  wire logic        clock_stopped,
    // external bus pins
    output logic [23:0]      addr_pin,
    input  wire logic [15:0] data_in,
    output logic [15:0]      data_out,
    output logic [15:0]      data_oe,
    output logic             io_read_strobe_n,
    output logic             io_write_strobe_n,
    output logic             mem_read_strobe_n,
    output logic             mem_write_strobe_n
);
    typedef struct packed
    {
        sbs_pkg::sbs_state_t st;
        logic [7:0]  mode;
        logic [7:0]  alt;
        logic [7:0]  mcfg;
        logic [7:0]  tom;
        logic [7:0]  dpwr;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        io;
        logic        wr;
        logic        word;
        logic        half;
        logic        refr;
        logic        blk;
        logic [2:0]  tgt;
        logic [15:0] wd;
        logic [15:0] rd;
        logic [15:0] hold;
        logic [23:0] addr;
        logic [15:0] dout;
        logic [15:0] doe;
        logic        ior_n;
        logic        iow_n;
        logic        mrd_n;
        logic        mwr_n;
        logic        done;
    } sbs_regs_t;

    sbs_regs_t state_reg;
    sbs_regs_t state_next;

    logic        wide;
    logic        split;
    logic [1:0]  lanes;
    logic [15:0] lane_data;
    logic        odd_b;

    assign odd_b = state_reg.addr[0];

    sbs_steer u_steer
    (
        .tgt               (state_reg.tgt),
        .odd_byte          (odd_b),
        .word_op           (state_reg.word),
        .second_half       (state_reg.half),
        .wdata             (state_reg.wd),
        .rom0_width_pin    (rom0_width_pin),
        .rom1_width_bit    (state_reg.mcfg[sbs_pkg::BIT_ROM1_WIDE]),
        .card_mem_size_bit (state_reg.mcfg[sbs_pkg::BIT_CMEM_WIDE]),
        .card_io_size_bit  (state_reg.mcfg[sbs_pkg::BIT_CIO_WIDE]),
        .card_wp_pin       (card_wp_pin),
        .memcs16_en        (memcs16_en),
        .memcs16_n         (memcs16_n),
        .iocs16_en         (iocs16_en),
        .iocs16_n          (iocs16_n),
        .wide              (wide),
        .split             (split),
        .lanes             (lanes),
        .pin_data          (lane_data)
    );

    // cpu page (16k) of an address
    function automatic logic [5:0] page_of(input logic [19:0] a);
        page_of = a[19:14];
    endfunction : page_of

    // true when the page lies in the active display window
    function automatic logic in_window(input logic [5:0] pg,
                                       input logic win);
        if (win)
            in_window = (pg[5:2] == sbs_pkg::PG_WIN_A0[5:2]);
        else
            in_window = (pg[5:1] == sbs_pkg::PG_WIN_B8[5:1]);
    endfunction : in_window

    // physical address: last bank number in mcfg[2:0], 512k per bank, 24-bit
    logic [2:0]  last_bank;
    logic [5:0]  cpu_pg;
    logic        win_hit;
    logic [16:0] buf_off;
    logic [23:0] map_addr;
    logic [23:0] io_addr;
    logic [23:0] refr_addr;
    logic        over_tom;

    assign last_bank = state_reg.mcfg[2:0];
    assign cpu_pg    = page_of(cpu_address_bits);
    assign win_hit   = in_window(cpu_pg,
                         state_reg.mcfg[sbs_pkg::BIT_WIN_SEL]);
    assign over_tom  = (cpu_pg < sbs_pkg::PG_DOS_TOP)
                       && (cpu_pg >= state_reg.tom[5:0]);

    always_comb
    begin
        // primary buffer sits at top of last bank
        if (state_reg.mcfg[sbs_pkg::BIT_SMALL_BUF])
            buf_off = {3'b111, cpu_address_bits[13:0]};
        else if (state_reg.mcfg[sbs_pkg::BIT_WIN_SEL])
            buf_off = {1'b1, cpu_address_bits[15:0]};
        else
            buf_off = {2'b11, cpu_address_bits[14:0]};
    end

    assign map_addr = win_hit
        ? {2'h0, last_bank, 2'b11, buf_off}
        : {4'h0, cpu_address_bits};
    assign io_addr  = {state_reg.mode[sbs_pkg::BIT_LATCH]
                       ? state_reg.addr[23:16] : 8'h00,
                       cpu_address_bits[15:0]};
    assign refr_addr = state_reg.alt[sbs_pkg::BIT_ALT_EN]
        ? {8'hff, state_reg.alt[6:0], refresh_word_offset[8:1], 1'b0}
        : {8'hff, refresh_word_offset, 1'b0};

    // apb read mux
    function automatic logic [31:0] reg_read(input sbs_regs_t s,
                                             input logic [7:0] a);
        case (a)
            sbs_pkg::ADDR_BUS_MODE:  reg_read = {24'h0, s.mode};
            sbs_pkg::ADDR_ALT_START: reg_read = {24'h0, s.alt};
            sbs_pkg::ADDR_MEM_CFG:   reg_read = {16'h0, s.tom, s.mcfg};
            sbs_pkg::ADDR_DATA_PWR:  reg_read = {24'h0, s.dpwr};
            sbs_pkg::ADDR_STATUS:    reg_read = {23'h0, s.blk, s.st,
                                                 s.tgt, s.refr};
            default:                 reg_read = 32'h0;
        endcase
    endfunction : reg_read

    function automatic logic known(input logic [7:0] a);
        known = (a == sbs_pkg::ADDR_BUS_MODE) || (a == sbs_pkg::ADDR_ALT_START)
             || (a == sbs_pkg::ADDR_MEM_CFG)  || (a == sbs_pkg::ADDR_DATA_PWR)
             || (a == sbs_pkg::ADDR_STATUS);
    endfunction : known

    logic ext_tgt;
    logic internal;
    assign internal = (state_reg.tgt == sbs_pkg::TGT_INT);
    assign ext_tgt  = ~internal;

    always_comb
    begin
        state_next         = state_reg;
        state_next.pready  = 1'b0;
        state_next.pslverr = 1'b0;
        state_next.done    = 1'b0;
        // apb slave answers one cycle into the access phase
        if (psel && penable && !state_reg.pready)
        begin
            state_next.pready  = 1'b1;
            state_next.pslverr = ~known(paddr);
            state_next.prdata  = reg_read(state_reg, paddr);
        end
        // a write lands only on the edge at which the master sees pready
        if (psel && penable && pwrite && state_reg.pready)
        begin
            case (paddr)
                sbs_pkg::ADDR_BUS_MODE:  state_next.mode = pwdata[7:0];
                sbs_pkg::ADDR_ALT_START: state_next.alt  = pwdata[7:0];
                sbs_pkg::ADDR_MEM_CFG:
                begin
                    state_next.mcfg = pwdata[7:0];
                    state_next.tom  = pwdata[15:8];
                end
                sbs_pkg::ADDR_DATA_PWR:
                    state_next.dpwr = pwdata[7:0];
                default: ;
            endcase
        end
        case (state_reg.st)
            sbs_pkg::ST_IDLE:
            begin
                if (refresh_req)
                begin
                    state_next.refr = 1'b1;
                    state_next.addr = refr_addr;
                    state_next.st   = sbs_pkg::ST_DONE;
                end
                else if (cyc_start)
                begin
                    state_next.refr = 1'b0;
                    state_next.io   = cyc_io;
                    state_next.wr   = cyc_write;
                    state_next.word = cyc_word;
                    state_next.half = 1'b0;
                    state_next.tgt  = cyc_tgt;
                    state_next.wd   = cyc_wdata;
                    state_next.blk  = ~cyc_io & over_tom & ~win_hit;
                    if (cyc_io)
                        state_next.addr = io_addr;
                    else if (state_reg.mode[sbs_pkg::BIT_LATCH]
                             && cyc_tgt != sbs_pkg::TGT_RAM)
                        state_next.addr = {state_reg.addr[23:20],
                                           map_addr[19:0]};
                    else
                        state_next.addr = map_addr;
                    state_next.st = sbs_pkg::ST_ADDR;
                end
            end
            sbs_pkg::ST_ADDR:
            begin
                if (state_reg.blk)
                    state_next.st = sbs_pkg::ST_DONE;
                else
                begin
                    state_next.st = sbs_pkg::ST_DATA;
                    if (!(internal && state_reg.mode[sbs_pkg::BIT_INHIBIT]))
                    begin
                        state_next.ior_n = ~(state_reg.io & ~state_reg.wr);
                        state_next.iow_n = ~(state_reg.io & state_reg.wr);
                        state_next.mrd_n = ~(~state_reg.io & ~state_reg.wr
                            & (state_reg.tgt != sbs_pkg::TGT_RAM)
                            & ((state_reg.tgt != sbs_pkg::TGT_ROM0
                                && state_reg.tgt != sbs_pkg::TGT_ROM1)
                               | state_reg.dpwr[sbs_pkg::BIT_ROM_OE_EN]));
                        state_next.mwr_n = ~(~state_reg.io & state_reg.wr
                            & (state_reg.tgt != sbs_pkg::TGT_RAM)
                            & (state_reg.tgt != sbs_pkg::TGT_ROM0)
                            & (state_reg.tgt != sbs_pkg::TGT_ROM1));
                        if (state_reg.wr)
                        begin
                            state_next.dout = lane_data;
                            state_next.doe  = {{8{lanes[1]}},
                                               {8{lanes[0]}}};
                        end
                        else
                            state_next.doe = 16'h0000;
                    end
                end
            end
            sbs_pkg::ST_DATA:
            begin
                state_next.ior_n = 1'b1;
                state_next.iow_n = 1'b1;
                state_next.mrd_n = 1'b1;
                state_next.mwr_n = 1'b1;
                if (!state_reg.wr)
                begin
                    if (state_reg.half)
                        state_next.rd = {data_in[7:0], state_reg.rd[7:0]};
                    else if (split || !odd_b || wide)
                        state_next.rd = data_in;
                    else
                        state_next.rd = {data_in[7:0], 8'h00};
                end
                if (ext_tgt)
                    state_next.hold = state_reg.wr ? lane_data : data_in;
                if (split && !state_reg.half)
                begin
                    state_next.half = 1'b1;
                    state_next.st   = sbs_pkg::ST_ADDR;
                    state_next.addr = state_reg.addr | 24'h000001;
                end
                else
                    state_next.st = sbs_pkg::ST_DONE;
            end
            sbs_pkg::ST_DONE:
            begin
                state_next.done = ~state_reg.refr;
                state_next.st   = sbs_pkg::ST_IDLE;
                if (state_reg.dpwr[sbs_pkg::BIT_HOLD_EN] && !state_reg.refr)
                begin
                    state_next.dout = state_reg.hold;
                    state_next.doe  = 16'hffff;
                end
                else
                    state_next.doe = 16'h0000;
            end
            default: state_next.st = sbs_pkg::ST_IDLE;
        endcase
        if (clock_stopped && state_reg.dpwr[sbs_pkg::BIT_CLAMP_EN])
        begin
            state_next.dout = 16'h0000;
            state_next.doe  = 16'hffff;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg       <= '0;
            state_reg.st    <= sbs_pkg::ST_IDLE;
            state_reg.mode  <= sbs_pkg::RST_BUS_MODE;
            state_reg.alt   <= sbs_pkg::RST_ALT_START;
            state_reg.mcfg  <= sbs_pkg::RST_MEM_CFG;
            state_reg.tom   <= sbs_pkg::RST_TOM;
            state_reg.dpwr  <= sbs_pkg::RST_DATA_PWR;
            state_reg.ior_n <= 1'b1;
            state_reg.iow_n <= 1'b1;
            state_reg.mrd_n <= 1'b1;
            state_reg.mwr_n <= 1'b1;
        end
        else
            state_reg <= state_next;
    end

    assign prdata             = state_reg.prdata;
    assign pready             = state_reg.pready;
    assign pslverr            = state_reg.pslverr;
    assign cyc_done           = state_reg.done;
    assign cyc_block          = state_reg.blk;
    assign cyc_rdata          = state_reg.rd;
    assign addr_pin           = state_reg.addr;
    assign data_out           = state_reg.dout;
    assign data_oe            = state_reg.doe;
    assign io_read_strobe_n   = state_reg.ior_n;
    assign io_write_strobe_n  = state_reg.iow_n;
    assign mem_read_strobe_n  = state_reg.mrd_n;
    assign mem_write_strobe_n = state_reg.mwr_n;

    a_ram_no_mstrb: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_reg.tgt == sbs_pkg::TGT_RAM && !state_reg.refr)
        |-> (mem_read_strobe_n && mem_write_strobe_n))
        else $error("memory strobe during ram access");
    a_inhibit_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (internal && state_reg.mode[sbs_pkg::BIT_INHIBIT])
        |-> (io_read_strobe_n && io_write_strobe_n))
        else $error("i/o strobe under bus inhibit");
    a_refresh_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_reg.st == sbs_pkg::ST_IDLE && refresh_req)
        |=> (addr_pin[23:16] == 8'hff))
        else $error("refresh address not high");
    a_clamp_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (clock_stopped && state_reg.dpwr[sbs_pkg::BIT_CLAMP_EN])
        |=> (data_oe == 16'hffff && data_out == 16'h0000))
        else $error("data not clamped low");
    a_io_low_addr: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_reg.st == sbs_pkg::ST_IDLE && !refresh_req && cyc_start
         && cyc_io && !state_reg.mode[sbs_pkg::BIT_LATCH])
        |=> (addr_pin == {8'h00, $past(cpu_address_bits[15:0])}))
        else $error("i/o address wrong");
    a_read_no_drive: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_reg.st == sbs_pkg::ST_DATA && !state_reg.wr
         && state_reg.dpwr == 8'h00) |-> (data_oe == 16'h0000))
        else $error("data driven on read");
    a_hold_drive: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_reg.st == sbs_pkg::ST_DONE && !state_reg.refr
         && state_reg.dpwr[1:0] == 2'b01) |=> (data_oe == 16'hffff))
        else $error("hold value not driven");
    a_apb_answer: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (psel && penable && !pready) |=> pready)
        else $error("apb answer late");
    c_refresh: cover property (@(posedge ref_clk) disable iff (!rst_n)
        refresh_req && state_reg.alt[sbs_pkg::BIT_ALT_EN]);
    c_split: cover property (@(posedge ref_clk) disable iff (!rst_n)
        split && state_reg.half);
    c_block: cover property (@(posedge ref_clk) disable iff (!rst_n)
        cyc_block);
endmodule : sbs_bridge

// ==== verification/sbs_isa_model.sv ====
// shared bus peripheral model: 8-bit targets answering reads
`timescale 1ns/1ps
module sbs_isa_model
(
    // bus pins
    input  wire logic        ref_clk,
    input  wire logic [23:0] addr_pin,
    input  wire logic [15:0] data_out,
    input  wire logic [15:0] data_oe,
    input  wire logic        io_read_strobe_n,
    input  wire logic        mem_read_strobe_n,
    // answers
    output logic [15:0]      data_in,
    output logic             memcs16_n,
    output logic             iocs16_n
);
    logic [15:0] last = 16'h0000;
    logic        rd;
    assign rd = !io_read_strobe_n || !mem_read_strobe_n;
    // undriven lines toggle while no read strobe is low; during a read they carry addr_pin[15:0] xor 5a3c
    assign data_in = (data_oe & data_out)
        | (~data_oe & (rd ? addr_pin[15:0] ^ 16'h5a3c : ~last));
    assign memcs16_n = 1'b1;
    assign iocs16_n = 1'b1;
    always @(posedge ref_clk) last <= data_in;
endmodule : sbs_isa_model

// ==== verification/tb_top.sv ====
// testbench for the shared bus bridge
`timescale 1ns/1ps
module tb_top;
    logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, q;
    logic pready, pslverr, e, cyc_start = 0, cyc_io = 0, cyc_write = 0;
    logic cyc_word = 0, cyc_done, cyc_block, refresh_req = 0;
    logic [2:0] cyc_tgt = 0;
    logic [19:0] cpu_address_bits = 0;
    logic [15:0] cyc_wdata = 0, cyc_rdata, data_in, data_out, data_oe;
    logic [15:1] refresh_word_offset = 0;
    logic clock_stopped = 0, memcs16_n, iocs16_n;
    logic rom0_w = 0, cs16_en = 0;
    logic [23:0] addr_pin, a_s;
    logic [15:0] oe_s, d_s;
    logic [3:0] st_s;
    logic io_read_strobe_n, io_write_strobe_n;
    logic mem_read_strobe_n, mem_write_strobe_n;
    int fail_count = 0, samples_checked = 0, cycles = 0;
    always #5 ref_clk = ~ref_clk;
    sbs_bridge dut (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .cyc_start, .cyc_io,
        .cyc_write, .cyc_word, .cyc_tgt, .cpu_address_bits, .cyc_wdata,
        .cyc_done, .cyc_block, .cyc_rdata, .refresh_req,
        .refresh_word_offset, .rom0_width_pin(rom0_w), .card_wp_pin(1'b0),
        .memcs16_en(cs16_en), .memcs16_n, .iocs16_en(cs16_en), .iocs16_n,
        .clock_stopped, .addr_pin, .data_in, .data_out, .data_oe,
        .io_read_strobe_n, .io_write_strobe_n, .mem_read_strobe_n,
        .mem_write_strobe_n);
    sbs_isa_model ext (.ref_clk, .addr_pin, .data_out, .data_oe,
        .io_read_strobe_n, .mem_read_strobe_n, .data_in, .memcs16_n,
        .iocs16_n);
    task report_and_stop;
        $display("checks %0d errors %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            fail_count++;
            report_and_stop();
        end
    end
    task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        samples_checked++;
        if (got !== ex)
        begin
            $display("MISMATCH %s exp %h got %h", nm, ex, got);
            fail_count++;
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk) penable <= 1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        q = prdata; e = pslverr; psel <= 0; penable <= 0;
        @(posedge ref_clk);
    endtask : apb
    task cyc(input logic io, w, input logic [2:0] t, input logic [19:0] a,
             input logic [15:0] d);
        cyc_io <= io; cyc_write <= w; cyc_tgt <= t; cpu_address_bits <= a;
        cyc_wdata <= d; cyc_start <= 1;
        @(posedge ref_clk) cyc_start <= 0;
        @(posedge ref_clk);
        #1 a_s = addr_pin; oe_s = data_oe; d_s = data_out;
        st_s = {io_read_strobe_n, io_write_strobe_n,
                mem_read_strobe_n, mem_write_strobe_n};
        do @(posedge ref_clk); while (cyc_done !== 1'b1);
    endtask : cyc
    initial
    begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1;
        apb(0, sbs_pkg::ADDR_MEM_CFG, 0);
        chk("mem_cfg", {16'h0, sbs_pkg::RST_TOM, sbs_pkg::RST_MEM_CFG}, q);
        apb(0, sbs_pkg::ADDR_DATA_PWR, 0);
        chk("data_pwr", 0, q);
        apb(0, 8'h3c, 0);
        chk("slverr", 1, e);
        cyc(1, 1, sbs_pkg::TGT_XIO, 20'habcd4, 16'h1234);
        chk("io_addr", 24'h00bcd4, a_s);
        chk("io_strb", 4'hb, st_s);
        chk("io_data", 16'h0034, d_s);
        chk("io_oe", 16'h00ff, oe_s);
        cyc_word <= 1;
        cyc(0, 1, sbs_pkg::TGT_RAM, 20'h01000, 16'h5678);
        chk("ram_strb", 4'hf, st_s);
        chk("ram_data", 16'h5678, d_s);
        rom0_w <= 1;
        cyc(0, 1, sbs_pkg::TGT_ROM0, 20'hf0000, 16'hbeef);
        chk("rom0_data", 16'hbeef, d_s);
        chk("rom0_strb", 4'hf, st_s);
        cyc_word <= 0;
        cs16_en <= 1;
        cyc(0, 1, sbs_pkg::TGT_XMEM, 20'h20003, 16'h9a9a);
        chk("odd_oe", 16'h00ff, oe_s);
        chk("odd_data", 16'h009a, d_s);
        cyc_word <= 1;
        cyc(0, 0, sbs_pkg::TGT_XMEM, 20'h20000, 16'h0000);
        chk("split_rd", 16'h3d3c, cyc_rdata);
        cyc_word <= 0;
        refresh_req <= 1; refresh_word_offset <= 15'h1234;
        repeat (2) @(posedge ref_clk);
        #1 chk("rf_addr", {8'hff, 15'h1234, 1'b0}, addr_pin);
        @(posedge ref_clk) refresh_req <= 0;
        repeat (3) @(posedge ref_clk);
        apb(1, sbs_pkg::ADDR_BUS_MODE, 32'h4);
        cyc(1, 1, sbs_pkg::TGT_INT, 20'h00020, 16'h55aa);
        chk("inh_strb", 1, st_s[2]);
        chk("inh_oe", 0, oe_s);
        apb(1, sbs_pkg::ADDR_DATA_PWR, 32'h1);
        cyc(1, 0, sbs_pkg::TGT_XIO, 20'h00310, 0);
        chk("io_rd", 16'h592c, cyc_rdata);
        #1 chk("hold_oe", 16'hffff, data_oe);
        chk("hold_d", 8'h2c, data_out[7:0]);
        @(posedge ref_clk) clock_stopped <= 1;
        apb(1, sbs_pkg::ADDR_DATA_PWR, 32'h3);
        repeat (2) @(posedge ref_clk);
        #1 chk("clamp", 32'h0000ffff, {data_out, data_oe});
        @(posedge ref_clk) clock_stopped <= 0;
        apb(1, sbs_pkg::ADDR_MEM_CFG, 32'h1007);
        cyc(0, 0, sbs_pkg::TGT_RAM, 20'h50000, 0);
        chk("blk_hi", 1, cyc_block);
        cyc(0, 0, sbs_pkg::TGT_RAM, 20'hb8000, 0);
        chk("blk_win", 0, cyc_block);
        chk("win_addr", 24'h3f8000, a_s);
        report_and_stop();
    end
endmodule : tb_top
